// [decim_pkg.sv]
// Purpose: shared constants and carriers for the four-path decimation chain
// Assumes: one clock, synchronous active-high reset
// Notes: the modulator bits arrive from outside the clock domain
//
// Functional notes
// - four independent paths: voltage1, voltage2/temperature, current1, current2
// - each path takes one modulator bit per sample, at clock divided by eight
// - single-bit input is widened to 32-bit words for arithmetic, 24-bit words for output
// - each path yields one output word per 1024 clock cycles
// - decimator is third-order sinc: three integrators and three combs
// - first-order filter at output rate compensates the sinc passband droop
// - current sample instant shifts by signed 8-bit setting, -1/2 to +1/2 output word (-512 to +508 clocks)
package decim_pkg;

  localparam int CHANNELS      = 4;
  localparam int WORD_W        = 24;
  localparam int INPUT_DIV     = 8;
  localparam int OUTPUT_DIV    = 1024;
  localparam int DECIM         = OUTPUT_DIV / INPUT_DIV;
  localparam int ACC_W         = 32;
  localparam int PHASE_W       = 8;
  localparam int COEF_FRAC     = 14;

  // compensation coefficients in q4.14 form
  localparam logic signed [17:0] COMP_B0 = 18'sh05000;
  localparam logic signed [17:0] COMP_B1 = 18'sh3F000;
  localparam logic signed [17:0] COMP_A1 = 18'sh00000;

  typedef logic signed [WORD_W-1:0] word_t;

  typedef struct packed {
    logic  valid;
    word_t voltage1;
    word_t voltage2;
    word_t current1;
    word_t current2;
  } result_s;

  typedef struct packed {
    logic signed [PHASE_W-1:0] shift1;
    logic signed [PHASE_W-1:0] shift2;
  } phase_s;

endpackage : decim_pkg

// [sinc_path.sv]
// Purpose: one decimation path: sinc3 decimator then droop compensation
// Assumes: bit_valid pulses once per eight clocks, dump pulses per word
// Notes: dump may be moved by the phase shift to delay or advance the sample
`timescale 1ns/1ns
module sinc_path
#(
  parameter int ACC_W  = decim_pkg::ACC_W,
  parameter int WORD_W = decim_pkg::WORD_W
)
(
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  input  wire logic                     bit_in,
  input  wire logic                     bit_valid,
  input  wire logic                     dump,
  input  wire logic                     emit,
  output logic signed [WORD_W-1:0]      word_out
);

  logic signed [ACC_W-1:0] int1_reg, int2_reg, int3_reg;
  logic signed [ACC_W-1:0] dly1_reg, dly2_reg, dly3_reg;
  logic signed [ACC_W-1:0] comb1, comb2, comb3;
  logic signed [ACC_W-1:0] sample_reg;
  logic signed [ACC_W-1:0] x1_reg, y1_reg, y_next;
  logic signed [ACC_W-1:0] bipolar;

  // products need room for the coefficient bits before scaling back
  localparam int PROD_W = ACC_W + $bits(decim_pkg::COMP_B0);
  logic signed [PROD_W-1:0] acc;

  // bit 1 -> +1, bit 0 -> -1 widened to the accumulator width
  assign bipolar = bit_in ? ACC_W'(1) : -ACC_W'(1);

  // three cascaded integrators at the modulator rate
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      int1_reg <= '0;
      int2_reg <= '0;
      int3_reg <= '0;
    end
    else if (bit_valid)
    begin
      int1_reg <= int1_reg + bipolar;
      int2_reg <= int2_reg + int1_reg;
      int3_reg <= int3_reg + int2_reg;
    end
  end

  assign comb1 = int3_reg - dly1_reg;
  assign comb2 = comb1 - dly2_reg;
  assign comb3 = comb2 - dly3_reg;

  // three combs at the decimated rate
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      dly1_reg   <= '0;
      dly2_reg   <= '0;
      dly3_reg   <= '0;
      sample_reg <= '0;
    end
    else if (dump)
    begin
      dly1_reg   <= int3_reg;
      dly2_reg   <= comb1;
      dly3_reg   <= comb2;
      sample_reg <= comb3 >>> 0;
    end
  end

  // droop compensation: y = b0*x + b1*x1 + a1*y1, scaled, per output word
  assign acc = PROD_W'(decim_pkg::COMP_B0) * PROD_W'(sample_reg)
             + PROD_W'(decim_pkg::COMP_B1) * PROD_W'(x1_reg)
             + PROD_W'(decim_pkg::COMP_A1) * PROD_W'(y1_reg);
  assign y_next = ACC_W'(acc >>> decim_pkg::COEF_FRAC);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      x1_reg   <= '0;
      y1_reg   <= '0;
      word_out <= '0;
    end
    else if (emit)
    begin
      x1_reg   <= sample_reg;
      y1_reg   <= y_next;
      word_out <= WORD_W'(y_next);
    end
  end

endmodule : sinc_path

// [decim_chain.sv]
// Purpose: four-path sinc3 decimation chain with droop compensation
// Assumes: modulator bits are asynchronous and pass two flip-flops first
// Notes: phase shift moves the current paths' sampling instant
`timescale 1ns/1ns
module decim_chain
#(
  parameter int OUTPUT_DIV = decim_pkg::OUTPUT_DIV,
  parameter int INPUT_DIV  = decim_pkg::INPUT_DIV
)
(
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire logic [3:0]                 modulator_bits,
  input  wire decim_pkg::phase_s          sample_phase_shift,
  output decim_pkg::result_s              result
);

  localparam int CNT_W = $clog2(OUTPUT_DIV);
  localparam int SUB_W = $clog2(INPUT_DIV);

  logic [3:0]       sync1_reg, sync2_reg;
  logic [CNT_W-1:0] phase_cnt_reg;
  logic             bit_valid;
  logic             emit;
  logic [3:0]       dump;
  logic             valid_reg;
  decim_pkg::word_t words [decim_pkg::CHANNELS];

  // function: dump instant for a signed shift, in clock cycles
  function automatic logic [CNT_W-1:0] dump_point
  (
    input logic signed [decim_pkg::PHASE_W-1:0] shift
  );
    logic signed [CNT_W+1:0] off;
    off = (CNT_W+2)'(shift) <<< (CNT_W - decim_pkg::PHASE_W);
    dump_point = CNT_W'(off);
  endfunction : dump_point

  // two-flop synchroniser on the modulator streams
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= modulator_bits;
      sync2_reg <= sync1_reg;
    end
  end

  // free-running word counter; sample each eighth clock
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      phase_cnt_reg <= '0;
    else
      phase_cnt_reg <= phase_cnt_reg + CNT_W'(1);
  end

  assign bit_valid = (phase_cnt_reg[SUB_W-1:0] == SUB_W'(0));
  assign emit      = (phase_cnt_reg == CNT_W'(OUTPUT_DIV - 1));

  // voltage paths dump at zero, current paths at their shifted point
  always_comb
  begin
    dump[0] = (phase_cnt_reg == '0);
    dump[1] = (phase_cnt_reg == '0);
    dump[2] = (phase_cnt_reg == dump_point(sample_phase_shift.shift1));
    dump[3] = (phase_cnt_reg == dump_point(sample_phase_shift.shift2));
  end

  // one independent path per channel
  for (genvar g = 0; g < decim_pkg::CHANNELS; g++)
  begin : g_path
    sinc_path u_path
    (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .bit_in    (sync2_reg[g]),
      .bit_valid (bit_valid),
      .dump      (dump[g]),
      .emit      (emit),
      .word_out  (words[g])
    );
  end

  // common strobe, registered on the same edge as all paths register their words
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      valid_reg <= 1'b0;
    else
      valid_reg <= emit;
  end

  // one driver for the whole result carrier
  assign result = '{valid:    valid_reg,
                    voltage1: words[0],
                    voltage2: words[1],
                    current1: words[2],
                    current2: words[3]};

endmodule : decim_chain

// [decim_chain_chk.sv]
// Purpose: port checks for decim_chain
// Assumes: six steady words settle every path
// Notes: bind follows the module
`timescale 1ns/1ns
module decim_chain_chk
#(
  parameter int OUTPUT_DIV = 1024
)
(
  input wire logic               clk_sys,
  input wire logic               reset,
  input wire logic [3:0]         modulator_bits,
  input wire decim_pkg::phase_s  sample_phase_shift,
  input wire decim_pkg::result_s result
);
  logic [15:0] gap_reg;
  logic [15:0] calm_reg;
  logic        seen_reg;
  wire         calm = calm_reg > 16'(6 * OUTPUT_DIV);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // gap since strobe, first strobe seen, cycles of steady input
  always_ff @(posedge clk_sys)
  begin
    gap_reg <= (reset || result.valid) ? 16'h0000 : gap_reg + 16'h0001;
    seen_reg <= !reset && (seen_reg || result.valid);
    calm_reg <= (reset || $changed({modulator_bits, sample_phase_shift}))
      ? 16'h0000 : calm_reg + {15'h0000, calm_reg != 16'hFFFF};
  end
  function automatic decim_pkg::word_t lvl(input logic b);
    return b ? 24'h200000 : 24'hE00000;
  endfunction : lvl
  sequence strobe_s;
    result.valid ##1 !result.valid [*8];
  endsequence
  chk_strobe_alone: assert property
    (result.valid |-> strobe_s) else $error("width");
  chk_strobe_period: assert property
    (result.valid && seen_reg |-> gap_reg == 16'(OUTPUT_DIV - 1))
    else $error("period");
  chk_strobe_due: assert property
    (gap_reg < 16'(OUTPUT_DIV + 8)) else $error("late");
  chk_reset_clear: assert property
    ($fell(reset) |-> result == '0) else $error("reset");
  chk_word_hold: assert property
    (!result.valid |-> $stable(result[95:0])) else $error("hold");
  chk_volt_level: assert property
    (calm && result.valid |-> {result.voltage1, result.voltage2} ==
    {lvl(modulator_bits[0]), lvl(modulator_bits[1])}) else $error("volt");
  chk_curr_level: assert property
    (calm && result.valid |-> {result.current1, result.current2} ==
    {lvl(modulator_bits[2]), lvl(modulator_bits[3])}) else $error("curr");
endmodule : decim_chain_chk
bind decim_chain decim_chain_chk #(.OUTPUT_DIV(OUTPUT_DIV)) u_chk
  (.clk_sys(clk_sys), .reset(reset), .modulator_bits(modulator_bits),
  .sample_phase_shift(sample_phase_shift), .result(result));

// [mod_model.sv]
// Purpose: modulator stand-in, four single-bit streams
// Assumes: levels change on the clock edge
// Notes: a bit is held eight clocks
`timescale 1ns/1ns
module mod_model
(
  input  wire logic       clk_sys,
  input  wire logic [3:0] levels,
  output logic [3:0]      bits = 4'h0
);
  logic [2:0] tick_reg = 3'h5;
  // one new bit per path every eighth clock
  always @(posedge clk_sys)
  begin
    tick_reg <= tick_reg + 3'h1;
    if (tick_reg == 3'h0)
      bits <= levels;
  end
endmodule : mod_model

// [test_sigma_delta_decimation_chain.sv]
// Purpose: bench for decim_chain
// Assumes: steady streams settle in six words
// Notes: random levels, shifts and noise
`timescale 1ns/1ns
module test_sigma_delta_decimation_chain;
  logic               clk_sys = 1'b0;
  logic               reset = 1'b1;
  logic [3:0]         levels = 4'h0;
  logic [3:0]         modulator_bits;
  decim_pkg::phase_s  shift = '0;
  decim_pkg::result_s result;
  int                 errors = 0;
  int                 checked = 0;
  int                 seed = 3087;
  always #25 clk_sys = ~clk_sys;
  mod_model u_mod (.clk_sys(clk_sys), .levels(levels),
    .bits(modulator_bits));
  decim_chain DUT (.clk_sys(clk_sys), .reset(reset),
    .modulator_bits(modulator_bits), .sample_phase_shift(shift),
    .result(result));
  function automatic decim_pkg::word_t expect_level(input logic b);
    return b ? 24'h200000 : 24'hE00000;
  endfunction : expect_level
  task automatic cmp_word(input string name, input decim_pkg::word_t e,
    input decim_pkg::word_t g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : cmp_word
  // hold levels and shifts for eight strobes, then check settled words
  task automatic run_round(input logic [3:0] lv, input logic [15:0] sh);
    int n;
    @(posedge clk_sys);
    levels <= lv;
    shift <= sh;
    repeat (8)
    begin
      n = 0;
      while (result.valid !== 1'b1 && n < 2000)
      begin
        @(posedge clk_sys) #1;
        n++;
      end
      if (n >= 2000)
      begin
        errors++;
        print_verdict();
      end
      @(posedge clk_sys) #1;
    end
    cmp_word("v1", expect_level(lv[0]), result.voltage1);
    cmp_word("v2", expect_level(lv[1]), result.voltage2);
    cmp_word("i1", expect_level(lv[2]), result.current1);
    cmp_word("i2", expect_level(lv[3]), result.current2);
  endtask : run_round
  task automatic print_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // corner shifts and levels, a noise burst, then random rounds
  initial
  begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    run_round(4'h5, 16'h0000);
    run_round(4'hA, 16'h807F);
    repeat (3000) @(posedge clk_sys) levels <= 4'($random(seed));
    repeat (4) run_round(4'($random(seed)), 16'($random(seed)));
    print_verdict();
  end
  // watchdog
  initial
  begin
    #4000000;
    errors++;
    print_verdict();
  end
endmodule : test_sigma_delta_decimation_chain
